// [rtl/wpg_guard.sv]
// Write permission guard: decides which writes may proceed and tracks active/standby.
// Assumes bus framing is decoded elsewhere and delivered as one-cycle event pulses.
`timescale 1ns/1ps
// Functional notes
// - Write-protect high refuses every nonvolatile write of any target.
// - Nonvolatile cycle starts only after a correctly framed transfer ends in STOP.
// - Write-protect high: only volatile pot writes pass, and only with both locks clear.
// - Write-protect low, lock set: no pot writes, memory outside lock, control writable.
// - Any START moves the device from standby to active.
// - Address mismatch returns to standby nine serial clocks after START.
// - STOP ending a read returns to standby 200 ns later.
// - STOP launching a permitted nonvolatile write stays active for the full write interval; other writes get 200 ns.
// - A STOP launching a write cycle gets the write interval, not 200 ns.
// - Lock pair 00 none, 01 C0h-FFh, 10 80h-FFh, 11 whole array.
// - No write proceeds without the write enable latch set; no acknowledge then.
// - Writes into a protected memory region are abandoned, array unchanged.
module wpg_guard
	import wpg_pkg::*;
#(
	parameter int unsigned NV_CYC = NV_WRITE_CYC
) (
	// System
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins and framing events
	input  wire logic        write_protect,
	input  wire logic        start_evt,
	input  wire logic        stop_evt,
	input  wire logic        scl_rise,
	input  wire logic        addr_mismatch,
	input  wire logic        frame_ok,
	input  wire logic        xfer_is_write,
	input  wire logic        write_nv,
	input  wire logic [1:0]  write_target,
	input  wire logic [7:0]  write_addr,
	// Decisions
	output logic             write_allowed,
	output logic             nv_launch,
	output logic             device_active,
	output logic             nv_busy
);
	// A write interval shorter than the STOP idle time cannot be served
	if (NV_CYC < STOP_IDLE_CYC) begin : g_nv_cyc_check
		$error("NV_CYC must be at least the STOP idle count");
	end

	localparam int CW = $clog2(NV_CYC + 1) + 1;

	logic [2:0]     ctrl_q;
	wpg_state_t     state_q;
	logic [CW-1:0]  cnt_q;
	logic [3:0]     scl_cnt_q;
	logic           ack_q;
	logic           lock_hit;
	logic           perm;
	wire  logic     lock_any = ctrl_q[CTRL_LOCK_HI_BIT] | ctrl_q[CTRL_LOCK_LO_BIT];
	wire  logic     wb_req   = wb_cyc_i & wb_stb_i;

	// Lock region from the pair
	always_comb begin
		case ({ctrl_q[CTRL_LOCK_HI_BIT], ctrl_q[CTRL_LOCK_LO_BIT]})
			2'b01:   lock_hit = write_addr >= LOCK_QUARTER_LO;
			2'b10:   lock_hit = write_addr >= LOCK_HALF_LO;
			2'b11:   lock_hit = 1'b1;
			default: lock_hit = 1'b0;
		endcase
	end

	// Permission table
	always_comb begin
		perm = 1'b0;
		if (write_protect) begin
			perm = !write_nv && write_target == WPG_TGT_POT && !lock_any;
		end else begin
			case (write_target)
				WPG_TGT_POT:  perm = !lock_any;
				WPG_TGT_MEM:  perm = !lock_hit;
				WPG_TGT_CTRL: perm = 1'b1;
				default:      perm = 1'b0;
			endcase
		end
		if (!ctrl_q[CTRL_WEL_BIT]) begin
			perm = 1'b0;
		end
	end

	assign write_allowed = perm;
	// Judged at the launching STOP only
	assign nv_launch = stop_evt && state_q == WPG_ACTIVE && xfer_is_write && write_nv
		&& frame_ok && perm;
	assign device_active = state_q != WPG_STANDBY;
	assign nv_busy       = state_q == WPG_NVWRITE;

	// Activity state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= WPG_STANDBY;
			cnt_q     <= '0;
			scl_cnt_q <= 4'h0;
		end else begin
			case (state_q)
				WPG_STANDBY: begin
					if (start_evt) begin
						state_q   <= WPG_ACTIVE;
						scl_cnt_q <= 4'h0;
						cnt_q     <= '0;
					end
				end
				WPG_ACTIVE: begin
					if (start_evt) begin
						scl_cnt_q <= 4'h0;
						cnt_q     <= '0;
					end else if (nv_launch) begin
						state_q <= WPG_NVWRITE;
						cnt_q   <= CW'(NV_CYC);
					end else if (stop_evt) begin
						cnt_q <= CW'(STOP_IDLE_CYC);
					end else if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
						if (cnt_q == CW'(1)) state_q <= WPG_STANDBY;
					end else if (addr_mismatch && scl_rise) begin
						scl_cnt_q <= scl_cnt_q + 4'h1;
						if (scl_cnt_q == 4'(MISMATCH_SCL - 1)) state_q <= WPG_STANDBY;
					end else if (scl_rise && scl_cnt_q < 4'(MISMATCH_SCL)) begin
						scl_cnt_q <= scl_cnt_q + 4'h1;
					end
				end
				WPG_NVWRITE: begin
					cnt_q <= cnt_q - 1'b1;
					if (cnt_q == CW'(1)) state_q <= WPG_STANDBY;
				end
				default: state_q <= WPG_STANDBY;
			endcase
		end
	end

	// Control register over Wishbone
	// Write lands on the acknowledged edge, the only one the master commits to
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (wb_req && wb_we_i && ack_q && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
			ctrl_q <= wb_dat_i[2:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req && !ack_q;
			case (wb_adr_i)
				OFS_CTRL:   wb_dat_o <= {29'h0, ctrl_q};
				OFS_STATUS: wb_dat_o <= {29'h0, nv_busy, device_active, write_allowed};
				default:    wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
	// Unmapped addresses still ack and read zero, so a stray access never hangs
	assign wb_ack_o = ack_q;

	a_wp_blocks_nv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		write_protect && write_nv |-> !write_allowed)
		else $error("nonvolatile write allowed under write protect");
	a_wp_pot_vol: assert property (@(posedge sys_clk) disable iff (!rst_n)
		write_protect && !write_nv && write_target == WPG_TGT_POT && ctrl_q == 3'h4
		|-> write_allowed)
		else $error("volatile pot write refused with locks clear");
	a_lock_pot_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
		lock_any && write_target == WPG_TGT_POT |-> !write_allowed)
		else $error("pot write allowed while locked");
	a_no_wel_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctrl_q[CTRL_WEL_BIT] |-> !write_allowed)
		else $error("write allowed without enable latch");
	a_quarter_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl_q[1:0] == 2'b01 && write_target == WPG_TGT_MEM && write_addr < LOCK_QUARTER_LO
		&& ctrl_q[2] && !write_protect |-> write_allowed)
		else $error("quarter lock covers too much");
	a_launch_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nv_launch |-> frame_ok && stop_evt && !write_protect)
		else $error("write cycle launched without good frame");
	a_start_wakes: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == WPG_STANDBY && start_evt |=> device_active)
		else $error("start did not wake device");
	a_nv_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nv_launch |=> nv_busy [*8])
		else $error("write interval ended early");

	// Age of a plain STOP; a counter keeps the standby property short
	localparam int SW = $clog2(STOP_IDLE_CYC + 1);
	logic [SW-1:0]  stop_age_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_age_q <= '0;
		end else if (start_evt || nv_launch) begin
			stop_age_q <= '0;
		end else if (state_q == WPG_ACTIVE && stop_evt) begin
			stop_age_q <= SW'(1);
		end else if (stop_age_q != '0 && stop_age_q != SW'(STOP_IDLE_CYC)) begin
			stop_age_q <= stop_age_q + 1'b1;
		end
	end

	a_read_stop_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_age_q == SW'(STOP_IDLE_CYC) && !start_evt |=> !device_active)
		else $error("no standby 200 ns after stop");
	a_stop_holds_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_age_q != '0 && stop_age_q != SW'(STOP_IDLE_CYC) |-> device_active)
		else $error("standby entered before 200 ns after stop");
endmodule : wpg_guard

// [rtl/wpg_pkg.sv]
// Package for the write permission guard: timing counts, lock ranges, Wishbone offsets.
// Assumes a 100 MHz system clock.
package wpg_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned STOP_IDLE_NS     = 200;
	localparam int unsigned STOP_IDLE_CYC    = (STOP_IDLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned NV_WRITE_MS      = 10;
	localparam int unsigned NV_WRITE_CYC     = NV_WRITE_MS * CLK_MHZ * 1000;
	localparam int unsigned MISMATCH_SCL     = 9;
	localparam logic [7:0]  LOCK_QUARTER_LO  = 8'hC0;
	localparam logic [7:0]  LOCK_HALF_LO     = 8'h80;
	localparam logic [3:0]  OFS_CTRL         = 4'h0;
	localparam logic [3:0]  OFS_STATUS       = 4'h4;
	localparam int unsigned CTRL_LOCK_LO_BIT = 0;
	localparam int unsigned CTRL_LOCK_HI_BIT = 1;
	localparam int unsigned CTRL_WEL_BIT     = 2;
	localparam logic [2:0]  CTRL_RESET       = 3'h0;
	typedef enum logic [2:0] {
		WPG_STANDBY = 3'b001,
		WPG_ACTIVE  = 3'b010,
		WPG_NVWRITE = 3'b100
	} wpg_state_t;
	typedef enum logic [1:0] {
		WPG_TGT_MEM  = 2'h0,
		WPG_TGT_POT  = 2'h1,
		WPG_TGT_CTRL = 2'h2
	} wpg_target_t;
endpackage : wpg_pkg

// [tb/wpg_host_model.sv]
// Two-wire master stand-in: frame commands become framing event pulses.
// Assumes the guard samples events on rising sys_clk.
`timescale 1ns/1ps
module wpg_host_model (
	// System
	input  wire logic sys_clk,
	// Framing events
	output logic      start_evt,
	output logic      stop_evt,
	output logic      scl_rise,
	output logic      addr_mismatch,
	output logic      frame_ok,
	output logic      xfer_is_write,
	output logic      write_nv
);
	initial {start_evt, stop_evt, scl_rise, addr_mismatch, frame_ok, xfer_is_write, write_nv} = '0;
	task automatic open_frame(input logic bad_sel);
		@(posedge sys_clk);
		{start_evt, addr_mismatch} <= {1'b1, bad_sel};
		@(posedge sys_clk);
		start_evt <= 1'b0;
	endtask : open_frame
	task automatic pulse_scl(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			scl_rise <= 1'b1;
			@(posedge sys_clk);
			scl_rise <= 1'b0;
		end
	endtask : pulse_scl
	// Kind of the pending write, held as a level between frames
	task automatic set_kind(input logic nv);
		write_nv <= nv;
	endtask : set_kind
	// Flags stand only for the STOP cycle, as a real decoder drops them
	task automatic close_frame(input logic wr, input logic ok, input logic nv);
		@(posedge sys_clk);
		{stop_evt, xfer_is_write, frame_ok, write_nv} <= {1'b1, wr, ok, nv};
		@(posedge sys_clk);
		{stop_evt, xfer_is_write, frame_ok, write_nv, addr_mismatch} <= '0;
	endtask : close_frame
endmodule : wpg_host_model

// [tb/write_permission_guard_test.sv]
// Bench for the guard: results come back as status and control reads, plus a launch count.
// Assumes the host model and a short write interval.
`timescale 1ns/1ps
module write_permission_guard_test
	import wpg_pkg::*;
;
	logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
	logic        write_protect, wb_ack_o, write_allowed, nv_launch, device_active, nv_busy;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rng;
	logic [1:0]  write_target;
	logic [7:0]  write_addr;
	logic        start_evt, stop_evt, scl_rise, addr_mismatch, frame_ok, xfer_is_write, write_nv;
	logic [2:0]  exp_q[$];
	int          bad_count = 0, samples_checked = 0, cycles = 0, launches = 0;
	wpg_guard #(.NV_CYC(50)) dut_u (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .write_protect, .start_evt,
		.stop_evt, .scl_rise, .addr_mismatch, .frame_ok, .xfer_is_write, .write_nv,
		.write_target, .write_addr, .write_allowed, .nv_launch, .device_active, .nv_busy);
	wpg_host_model host_u (.sys_clk, .start_evt, .stop_evt, .scl_rise, .addr_mismatch,
		.frame_ok, .xfer_is_write, .write_nv);
	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic wb(input logic we, input logic [3:0] adr, input logic [2:0] dat);
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, 29'h0, dat};
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask : wb
	task automatic rd(input logic [2:0] e);
		exp_q.push_back(e);
		wb(1'b0, OFS_STATUS, 3'h0);
	endtask : rd
	task automatic rd_ctrl(input logic [2:0] e);
		exp_q.push_back(e);
		wb(1'b0, OFS_CTRL, 3'h0);
	endtask : rd_ctrl
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	function automatic logic perm(input logic write_enable_latch, wp, nv, input logic [1:0] lk, tg,
		input logic [7:0] a);
		if (!write_enable_latch)
			return 1'b0;
		if (tg == 2'h1)
			return lk == 2'b00 && !(wp && nv);
		if (tg == 2'h2)
			return !wp;
		return !wp && (lk == 2'b00 || (lk == 2'b01 && a < 8'hC0) || (lk == 2'b10 && a < 8'h80));
	endfunction : perm
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Stall guard: the whole run needs well under 2000 cycles
	always @(posedge sys_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			check(wb_dat_o, {29'h0, exp_q.pop_front()});
		if (nv_launch === 1'b1)
			launches++;
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		rng = 32'h0000_0016;
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, write_protect} <= 5'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i} <= {4'h0, 4'hF, 32'h0000_0000};
		{write_target, write_addr} <= 10'h000;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(3'h0);
		for (int i = 0; i < 96; i++) begin
			rng = xs(rng);
			wb(1'b1, OFS_CTRL, {i >= 48, i[3:2]});
			{write_protect, write_target, write_addr} <= {i[0], 2'((i / 16) % 3), rng[7:0]};
			host_u.set_kind(i[1]);
			rd({2'b00, perm(i >= 48, i[0], i[1], i[3:2], 2'((i / 16) % 3), rng[7:0])});
		end
		{write_protect, write_target} <= 3'b000;
		wb_sel_i <= 4'hE;
		wb(1'b1, OFS_CTRL, 3'h4);
		wb_sel_i <= 4'hF;
		rd_ctrl(3'h7);
		rd(3'h0);
		wb(1'b1, OFS_CTRL, 3'h4);
		host_u.open_frame(1'b0);
		rd(3'h3);
		host_u.close_frame(1'b0, 1'b1, 1'b0);
		repeat (8) @(posedge sys_clk);
		rd(3'h3);
		repeat (10) @(posedge sys_clk);
		rd(3'h1);
		host_u.open_frame(1'b0);
		host_u.close_frame(1'b1, 1'b1, 1'b1);
		repeat (30) @(posedge sys_clk);
		rd(3'h7);
		repeat (20) @(posedge sys_clk);
		rd(3'h1);
		host_u.open_frame(1'b0);
		host_u.close_frame(1'b1, 1'b0, 1'b1);
		rd(3'h3);
		write_protect <= 1'b1;
		host_u.open_frame(1'b0);
		host_u.close_frame(1'b1, 1'b1, 1'b1);
		repeat (25) @(posedge sys_clk);
		rd(3'h0);
		host_u.open_frame(1'b1);
		host_u.pulse_scl(8);
		rd(3'h2);
		host_u.pulse_scl(1);
		rd(3'h0);
		host_u.close_frame(1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge sys_clk);
		check(launches, 1);
		end_sim();
	end
endmodule : write_permission_guard_test
